// ### ocs_clock_ctrl.sv
// clock source selection, division and oscillator trim registers
// assumes oscillator outputs and usb timing flags are asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module ocs_clock_ctrl
    import ocs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire ocs_bus_t bus,
    output logic [7:0] rdata,
    input wire logic fast_osc_in,
    input wire logic slow_osc_in,
    input wire logic external_clock_input,
    input wire logic sleep_active,
    input wire logic boot_load,
    input wire logic usb_pkt_fast,
    input wire logic usb_pkt_slow,
    output ocs_clks_t clocks,
    output logic [7:0] fast_osc_trim_out,
    output logic [7:0] slow_osc_trim_out,
    output logic slow_osc_enable
);
    ////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HOLD = 2'b01,
        ST_SWAP = 2'b10
    } ocs_sw_t;

    typedef struct packed {
        logic [7:0] fast_trim;
        logic [7:0] slow_trim;
        logic [7:0] osc_ctrl0;
        logic [7:0] tmr_cfg;
        logic [7:0] usb_lock;
        logic [7:0] clk_misc;
        logic [7:0] rdata;
        logic [1:0] fast_s;
        logic [1:0] slow_s;
        logic [1:0] ext_s;
        logic [1:0] pktf_s;
        logic [1:0] pkts_s;
        logic [1:0] sleep_s;
        logic fast_d;
        logic slow_d;
        logic [DIV_W-1:0] cpu_cnt;
        logic [DIV_W-1:0] itmr_cnt;
        logic [DIV_W-1:0] tcap_cnt;
        logic cpu_clk;
        logic usb_clk;
        logic itmr_clk;
        logic tcap_clk;
        logic pin_clk;
        logic [2:0] cpu_act;
        logic [3:0] itmr_act;
        logic [3:0] tcap_act;
        logic [1:0] pin_act;
        ocs_sw_t sw_state;
    } ocs_state_t;

    ocs_state_t st_ff;
    ocs_state_t nxt_st;

    ////////////////////////////////////////////////////////////////////
    // divide-by-n half period counter; returns half-period length
    function automatic logic [DIV_W-1:0] cpu_half(input logic [2:0] code);
        logic [DIV_W-1:0] h;
        h = 8'h01;
        case (code)
            3'h0: h = 8'h04;
            3'h1: h = 8'h02;
            3'h2: h = 8'h01;
            3'h3: h = 8'h00;
            3'h4: h = 8'h08;
            3'h5: h = 8'h10;
            3'h6: h = 8'h40;
            default: h = 8'h04;
        endcase
        return h;
    endfunction

    // toggle divider step: edge = qualifying source edge
    function automatic logic [DIV_W:0] div_step(input logic [DIV_W-1:0] cnt,
                                               input logic [DIV_W-1:0] lim,
                                               input logic edge_in);
        logic [DIV_W:0] r;
        r = {1'b0, cnt};
        if (edge_in) begin
            if (cnt + 8'h01 >= lim) begin
                r = {1'b1, 8'h00};
            end else begin
                r = {1'b0, cnt + 8'h01};
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    logic fast_rise;
    logic slow_rise;
    logic sel_src_edge;
    logic [DIV_W:0] cpu_r;
    logic [DIV_W:0] itmr_r;
    logic [DIV_W:0] tcap_r;
    logic [DIV_W-1:0] itmr_lim;
    logic [DIV_W-1:0] tcap_lim;
    logic itmr_edge;
    logic tcap_edge;
    logic pin_src;
    logic tcap_prev;
    logic sel_change;
    logic low_all;
    logic [4:0] gain_n;
    logic [2:0] cpu_want;
    logic [3:0] itmr_want;
    logic [3:0] tcap_want;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = 8'h00;
        nxt_st.fast_s = {st_ff.fast_s[0], fast_osc_in};
        nxt_st.slow_s = {st_ff.slow_s[0], slow_osc_in};
        nxt_st.ext_s = {st_ff.ext_s[0], external_clock_input};
        nxt_st.pktf_s = {st_ff.pktf_s[0], usb_pkt_fast};
        nxt_st.pkts_s = {st_ff.pkts_s[0], usb_pkt_slow};
        nxt_st.sleep_s = {st_ff.sleep_s[0], sleep_active};
        nxt_st.fast_d = st_ff.fast_s[1];
        nxt_st.slow_d = st_ff.slow_s[1];
        fast_rise = st_ff.fast_s[1] & ~st_ff.fast_d;
        slow_rise = st_ff.slow_s[1] & ~st_ff.slow_d;

        // registers; boot load stands in for the boot rom trim write
        if (boot_load) begin
            nxt_st.fast_trim = FAST_TRIM_BOOT;
            nxt_st.slow_trim = SLOW_TRIM_BOOT & SLOW_TRIM_WMASK;
        end
        if (bus.wr) begin
            case (bus.addr)
                ADDR_FAST_TRIM: nxt_st.fast_trim = bus.wdata;
                ADDR_SLOW_TRIM: nxt_st.slow_trim = bus.wdata & SLOW_TRIM_WMASK;
                ADDR_OSC_CTRL0: nxt_st.osc_ctrl0 = bus.wdata & OSC_CTRL0_WMASK;
                ADDR_TMR_CFG: nxt_st.tmr_cfg = bus.wdata;
                ADDR_USB_LOCK: nxt_st.usb_lock = bus.wdata & USB_LOCK_WMASK;
                ADDR_CLK_MISC: nxt_st.clk_misc = bus.wdata & CLK_MISC_WMASK;
                default: nxt_st.clk_misc = st_ff.clk_misc;
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                ADDR_FAST_TRIM: nxt_st.rdata = st_ff.fast_trim;
                ADDR_SLOW_TRIM: nxt_st.rdata = st_ff.slow_trim;
                ADDR_OSC_CTRL0: nxt_st.rdata = st_ff.osc_ctrl0;
                ADDR_TMR_CFG: nxt_st.rdata = st_ff.tmr_cfg;
                ADDR_USB_LOCK: nxt_st.rdata = st_ff.usb_lock;
                ADDR_CLK_MISC: nxt_st.rdata = st_ff.clk_misc;
                ADDR_CPU_CFG: nxt_st.rdata = 8'h00;
                default: nxt_st.rdata = 8'h00;
            endcase
        end

        // usb lock: lower gain raises frequency, so a fast-detected packet
        // steps gain up and a slow one steps it down
        gain_n = st_ff.fast_trim[4:0];
        if (!st_ff.usb_lock[0] && !bus.wr) begin
            if (st_ff.pktf_s[1] && gain_n != 5'h1F) begin
                nxt_st.fast_trim[4:0] = gain_n + RETUNE_STEP;
            end else if (st_ff.pkts_s[1] && gain_n != 5'h00) begin
                nxt_st.fast_trim[4:0] = gain_n - RETUNE_STEP;
            end
        end

        // switch controller: park cpu, interval, capture and pin clocks low before new selection
        // reserved codes keep the running selection, else the switch would re-arm forever
        cpu_want = st_ff.osc_ctrl0[2:0];
        if (cpu_want == CPU_SPEED_RSVD) begin
            cpu_want = st_ff.cpu_act;
        end
        itmr_want = st_ff.tmr_cfg[3:0];
        if (itmr_want[1:0] == 2'h1) begin
            itmr_want = st_ff.itmr_act;
        end
        tcap_want = st_ff.tmr_cfg[7:4];
        if (tcap_want[1:0] == 2'h1) begin
            tcap_want = st_ff.tcap_act;
        end
        sel_change = (st_ff.cpu_act != cpu_want)
                   | (st_ff.itmr_act != itmr_want)
                   | (st_ff.tcap_act != tcap_want)
                   | (st_ff.pin_act != st_ff.clk_misc[1:0]);
        low_all = ~st_ff.cpu_clk & ~st_ff.itmr_clk & ~st_ff.tcap_clk & ~st_ff.pin_clk;
        case (st_ff.sw_state)
            ST_RUN: begin
                if (sel_change) begin
                    nxt_st.sw_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (low_all) begin
                    nxt_st.sw_state = ST_SWAP;
                end
            end
            ST_SWAP: begin
                nxt_st.cpu_act = cpu_want;
                nxt_st.itmr_act = itmr_want;
                nxt_st.tcap_act = tcap_want;
                nxt_st.pin_act = st_ff.clk_misc[1:0];
                nxt_st.cpu_cnt = 8'h00;
                nxt_st.itmr_cnt = 8'h00;
                nxt_st.tcap_cnt = 8'h00;
                nxt_st.sw_state = ST_RUN;
            end
            default: nxt_st.sw_state = ST_RUN;
        endcase

        // cpu clock: fast divided by 2^n
        cpu_r = div_step(st_ff.cpu_cnt, cpu_half(st_ff.cpu_act), fast_rise);
        if (st_ff.cpu_act == 3'h3) begin
            nxt_st.cpu_clk = st_ff.fast_s[1];
        end else begin
            nxt_st.cpu_cnt = cpu_r[DIV_W-1:0];
            if (cpu_r[DIV_W]) begin
                nxt_st.cpu_clk = ~st_ff.cpu_clk;
            end
        end

        // usb clock: fast divided by two, optional bypass bit
        if (st_ff.clk_misc[2]) begin
            nxt_st.usb_clk = st_ff.fast_s[1];
        end else if (fast_rise) begin
            nxt_st.usb_clk = ~st_ff.usb_clk;
        end

        // capture clock: divide 2,4,6,8 => half periods 1..4
        tcap_lim = {6'h00, st_ff.tcap_act[3:2]} + 8'h01;
        case (st_ff.tcap_act[1:0])
            SRC_FAST: tcap_edge = fast_rise;
            SRC_SLOW: tcap_edge = slow_rise & ~st_ff.sleep_s[1];
            default: tcap_edge = 1'b0;
        endcase
        tcap_r = div_step(st_ff.tcap_cnt, tcap_lim, tcap_edge);
        nxt_st.tcap_cnt = tcap_r[DIV_W-1:0];
        if (tcap_r[DIV_W]) begin
            nxt_st.tcap_clk = ~st_ff.tcap_clk;
        end
        tcap_prev = st_ff.tcap_clk;

        // interval clock: source then prescale 1..4
        case (st_ff.itmr_act[1:0])
            SRC_FAST: sel_src_edge = fast_rise;
            SRC_SLOW: sel_src_edge = slow_rise & ~st_ff.sleep_s[1];
            SRC_CAP: sel_src_edge = tcap_r[DIV_W] & ~tcap_prev;
            default: sel_src_edge = 1'b0;
        endcase
        itmr_edge = sel_src_edge;
        itmr_lim = {6'h00, st_ff.itmr_act[3:2]} + 8'h01;
        itmr_r = div_step(st_ff.itmr_cnt, itmr_lim, itmr_edge);
        nxt_st.itmr_cnt = itmr_r[DIV_W-1:0];
        if (itmr_r[DIV_W]) begin
            nxt_st.itmr_clk = 1'b1;
        end else if (itmr_edge || st_ff.itmr_act[3:2] == 2'h0) begin
            nxt_st.itmr_clk = 1'b0;
        end

        // clock output pin source
        case (ocs_pin_src_t'(st_ff.pin_act))
            OCS_PIN_EXT: pin_src = st_ff.ext_s[1];
            OCS_PIN_FAST: pin_src = st_ff.fast_s[1];
            OCS_PIN_SLOW: pin_src = st_ff.slow_s[1] & ~st_ff.sleep_s[1];
            OCS_PIN_CPU: pin_src = st_ff.cpu_clk;
            default: pin_src = 1'b0;
        endcase
        nxt_st.pin_clk = pin_src;

        // hold parks the cpu, interval, capture and pin clocks low until the swap; usb clock keeps running
        if (st_ff.sw_state != ST_RUN) begin
            nxt_st.cpu_clk = 1'b0;
            nxt_st.itmr_clk = 1'b0;
            nxt_st.tcap_clk = 1'b0;
            nxt_st.pin_clk = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.tmr_cfg <= TMR_CFG_RST;
            st_ff.itmr_act <= TMR_CFG_RST[3:0];
            st_ff.sw_state <= ST_RUN;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // slow oscillator never gated by sleep or power state
    assign slow_osc_enable = 1'b1;
    assign rdata = st_ff.rdata;
    assign clocks = {st_ff.cpu_clk, st_ff.usb_clk, st_ff.itmr_clk, st_ff.tcap_clk, st_ff.pin_clk};
    // offset and gain weights applied in the analog trim
    assign fast_osc_trim_out = st_ff.fast_trim;
    assign slow_osc_trim_out = st_ff.slow_trim;
endmodule
`default_nettype wire

// ### ocs_clock_ctrl_checker.sv
// assertions for the clock control block
// assumes it is bound onto ocs_clock_ctrl, single clock domain
`timescale 1ns/100ps
`default_nettype none
module ocs_clock_ctrl_checker
    import ocs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire ocs_bus_t bus,
    input wire logic [7:0] rdata,
    input wire logic boot_load,
    input wire logic usb_pkt_fast,
    input wire logic usb_pkt_slow,
    input wire logic [7:0] fast_osc_trim_out,
    input wire logic [7:0] slow_osc_trim_out,
    input wire logic slow_osc_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic lock_ff;
    logic [7:0] wd_ff;
    logic quiet;
    // retune flags would legally move the gain, so write checks need them low
    assign quiet = clk_en && !usb_pkt_fast && !usb_pkt_slow;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lock_ff <= 1'b1;
            wd_ff <= 8'h00;
        end else if (clk_en && bus.wr) begin
            wd_ff <= bus.wdata;
            if (bus.addr == ADDR_USB_LOCK)
                lock_ff <= !bus.wdata[0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_rd_idle;
        (clk_en && !bus.rd) |=> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    property p_rd_fast;
        (clk_en && bus.rd && bus.addr == ADDR_FAST_TRIM) |=> rdata == $past(fast_osc_trim_out);
    endproperty
    a_rd_fast: assert property (p_rd_fast) else $error("fast trim read wrong");
    property p_rd_slow;
        (clk_en && bus.rd && bus.addr == ADDR_SLOW_TRIM) |=> rdata == $past(slow_osc_trim_out);
    endproperty
    a_rd_slow: assert property (p_rd_slow) else $error("slow trim read wrong");
    property p_wr_fast;
        (quiet && bus.wr && bus.addr == ADDR_FAST_TRIM) |=> ##[0:1] fast_osc_trim_out == wd_ff;
    endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("fast trim write lost");
    property p_wr_slow;
        (quiet && bus.wr && bus.addr == ADDR_SLOW_TRIM)
            |=> ##[0:1] slow_osc_trim_out == (wd_ff & SLOW_TRIM_WMASK);
    endproperty
    a_wr_slow: assert property (p_wr_slow) else $error("slow trim write wrong");
    property p_boot;
        (quiet && boot_load && !bus.wr) |=> ##[0:1]
            (fast_osc_trim_out == FAST_TRIM_BOOT && slow_osc_trim_out == SLOW_TRIM_BOOT);
    endproperty
    a_boot: assert property (p_boot) else $error("boot trim not loaded");
    property p_rsvd;
        slow_osc_trim_out[6] == 1'b0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved slow trim bit set");
    property p_slow_on;
        !$past(reset) |-> slow_osc_enable;
    endproperty
    a_slow_on: assert property (p_slow_on) else $error("slow oscillator stopped");
    property p_retune;
        (clk_en && lock_ff && usb_pkt_fast && !bus.wr)[*5]
            |=> fast_osc_trim_out[4:0] != $past(fast_osc_trim_out[4:0]);
    endproperty
    a_retune: assert property (p_retune) else $error("gain not retuned");
    c_retune: cover property ((lock_ff && usb_pkt_fast)[*5]);
    c_boot: cover property (boot_load);
    c_read: cover property (bus.rd ##1 rdata != 8'h00);
endmodule
bind ocs_clock_ctrl ocs_clock_ctrl_checker chk_u (.clk(clk), .reset(reset), .clk_en(clk_en),
    .bus(bus), .rdata(rdata), .boot_load(boot_load), .usb_pkt_fast(usb_pkt_fast),
    .usb_pkt_slow(usb_pkt_slow), .fast_osc_trim_out(fast_osc_trim_out),
    .slow_osc_trim_out(slow_osc_trim_out), .slow_osc_enable(slow_osc_enable));
`default_nettype wire

// ### ocs_pkg.sv
// package for the oscillator clock select and trim block
// assumes one 200 MHz clock domain and a simple strobe register port
// Notes on behaviour
// - two sources, fast and slow oscillator
// - usb packets retune fast oscillator when enabled
// - slow oscillator keeps running through suspend
// - each consumer has its own clock select
// - cpu clock is fast divided by 2^n
// - usb clock is 12 MHz via divide-by-two
// - interval clock selects source then divides 1-4
// - capture clock selects fast or slow
// - clock pin driven by one of four sources
// - fast trim holds offset 7:5, gain 4:0
// - boot rom loads trim values at startup
// - offset bits add weighted frequency steps
// - gain bits set step size per offset
// - slow trim bit 7 selects low-power mode
// - slow trim holds bias 5:4, frequency 3:0
// - cpu speed codes map to fixed divisions
// - interval select and divide code mapping
// - capture divider codes divide by 2,4,6,8
`default_nettype none
package ocs_pkg;
    localparam int ADDR_W = 9;
    localparam logic [8:0] ADDR_CPU_CFG = 9'h030;
    localparam logic [8:0] ADDR_TMR_CFG = 9'h031;
    localparam logic [8:0] ADDR_FAST_TRIM = 9'h034;
    localparam logic [8:0] ADDR_SLOW_TRIM = 9'h036;
    localparam logic [8:0] ADDR_USB_LOCK = 9'h039;
    localparam logic [8:0] ADDR_OSC_CTRL0 = 9'h1E0;
    localparam logic [8:0] ADDR_CLK_MISC = 9'h038;
    localparam logic [7:0] TMR_CFG_RST = 8'h0C;
    localparam logic [7:0] SLOW_TRIM_WMASK = 8'hBF;
    localparam logic [7:0] OSC_CTRL0_WMASK = 8'h3F;
    localparam logic [7:0] USB_LOCK_WMASK = 8'h03;
    localparam logic [7:0] CLK_MISC_WMASK = 8'h0F;
    localparam logic [7:0] FAST_TRIM_BOOT = 8'h10;
    localparam logic [7:0] SLOW_TRIM_BOOT = 8'h08;
    localparam logic [2:0] CPU_SPEED_RSVD = 3'h7;
    localparam logic [1:0] SRC_FAST = 2'h0;
    localparam logic [1:0] SRC_SLOW = 2'h2;
    localparam logic [1:0] SRC_CAP = 2'h3;
    localparam logic [1:0] BIAS_RSVD = 2'h2;
    localparam logic [4:0] RETUNE_STEP = 5'h01;
    localparam int DIV_W = 8;

    typedef enum logic [1:0] {
        OCS_PIN_EXT = 2'b00,
        OCS_PIN_FAST = 2'b01,
        OCS_PIN_SLOW = 2'b10,
        OCS_PIN_CPU = 2'b11
    } ocs_pin_src_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ocs_bus_t;

    typedef struct packed {
        logic cpu;
        logic usb;
        logic itmr;
        logic tcap;
        logic pin;
    } ocs_clks_t;
endpackage
`default_nettype wire

// ### testbench.sv
// self-checking bench for the clock control block
// assumes ocs_clock_ctrl with its checker bound; bench drives all ports
`timescale 1ns/100ps
`default_nettype none
module testbench
    import ocs_pkg::*;
();
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic sleep_active = 1'b0;
    logic boot_load = 1'b0;
    logic usb_pkt_fast = 1'b0;
    logic usb_pkt_slow = 1'b0;
    logic fast_osc_in = 1'b0;
    logic slow_osc_in = 1'b0;
    logic slow_run = 1'b0;
    logic ext_in = 1'b0;
    logic clk_en = 1'b1;
    ocs_bus_t bus = '0;
    logic [7:0] rdata, fast_trim, slow_trim, d;
    logic slow_en;
    ocs_clks_t clocks;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    // fast source period is 8 bench cycles so the synchroniser sees every level
    always #20 fast_osc_in = ~fast_osc_in;
    always #100 slow_osc_in = slow_run ? ~slow_osc_in : 1'b0;
    // external clock period is 16 bench cycles
    always #40 ext_in = ~ext_in;
    ocs_clock_ctrl dut_u (.clk(clk), .reset(reset), .clk_en(clk_en), .bus(bus), .rdata(rdata),
        .fast_osc_in(fast_osc_in), .slow_osc_in(slow_osc_in), .external_clock_input(ext_in),
        .sleep_active(sleep_active), .boot_load(boot_load), .usb_pkt_fast(usb_pkt_fast),
        .usb_pkt_slow(usb_pkt_slow), .clocks(clocks), .fast_osc_trim_out(fast_trim),
        .slow_osc_trim_out(slow_trim), .slow_osc_enable(slow_en));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rdc(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
        chk(rdata, exp);
    endtask
    // counts rising edges of one derived clock over 160 cycles after settling
    task automatic freq(input int b, input int lo, input int hi);
        int n;
        logic p;
        n = 0;
        repeat (30) @(posedge clk);
        p = clocks[b];
        repeat (160) begin
            @(posedge clk);
            #1;
            if (clocks[b] && !p)
                n++;
            p = clocks[b];
        end
        chk({7'h00, n >= lo && n <= hi}, 8'h01);
    endtask
    task automatic pulse(input logic f);
        usb_pkt_fast <= f;
        usb_pkt_slow <= !f;
        repeat (8) @(posedge clk);
        usb_pkt_fast <= 1'b0;
        usb_pkt_slow <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdc(ADDR_TMR_CFG, TMR_CFG_RST);
        rdc(ADDR_OSC_CTRL0, 8'h00);
        chk({7'h00, slow_en}, 8'h01);
        @(posedge clk);
        boot_load <= 1'b1;
        @(posedge clk);
        boot_load <= 1'b0;
        rdc(ADDR_FAST_TRIM, FAST_TRIM_BOOT);
        rdc(ADDR_SLOW_TRIM, SLOW_TRIM_BOOT);
        wr(ADDR_FAST_TRIM, 8'hA5);
        rdc(ADDR_FAST_TRIM, 8'hA5);
        wr(ADDR_FAST_TRIM, 8'h5A);
        rdc(ADDR_FAST_TRIM, 8'h5A);
        chk(fast_trim, 8'h5A);
        wr(ADDR_SLOW_TRIM, 8'hFF);
        rdc(ADDR_SLOW_TRIM, 8'hBF);
        wr(ADDR_SLOW_TRIM, 8'h1C);
        rdc(ADDR_SLOW_TRIM, 8'h1C);
        wr(ADDR_SLOW_TRIM, d | 8'h80);
        rdc(ADDR_SLOW_TRIM, 8'h9C);
        chk(slow_trim, 8'h9C);
        wr(9'h035, 8'hFF);
        rdc(9'h035, 8'h00);
        $display("TB: register test done");
    endtask
    task automatic t_clocks();
        freq(0, 9, 11);
        wr(ADDR_OSC_CTRL0, 8'h03);
        freq(4, 18, 22);
        wr(ADDR_OSC_CTRL0, 8'h02);
        freq(4, 9, 11);
        wr(ADDR_OSC_CTRL0, 8'h07);
        freq(4, 9, 11);
        freq(3, 9, 11);
        wr(ADDR_TMR_CFG, 8'h04);
        freq(2, 9, 11);
        freq(1, 9, 11);
        wr(ADDR_TMR_CFG, 8'h40);
        freq(2, 18, 22);
        freq(1, 4, 6);
        wr(ADDR_TMR_CFG, 8'h43);
        freq(2, 4, 6);
        wr(ADDR_CLK_MISC, 8'h01);
        freq(0, 18, 22);
        wr(ADDR_CLK_MISC, 8'h03);
        freq(0, 9, 11);
        wr(ADDR_CLK_MISC, 8'h04);
        freq(3, 18, 22);
        $display("TB: clock rate test done");
    endtask
    task automatic t_sleep();
        wr(ADDR_TMR_CFG, 8'h22);
        wr(ADDR_CLK_MISC, 8'h02);
        rdc(ADDR_TMR_CFG, 8'h22);
        rdc(ADDR_TMR_CFG, d);
        sleep_active <= 1'b1;
        slow_run = 1'b1;
        freq(0, 0, 0);
        freq(1, 0, 0);
        freq(2, 0, 0);
        sleep_active <= 1'b0;
        freq(0, 3, 5);
        freq(1, 1, 3);
        freq(2, 3, 5);
        slow_run = 1'b0;
        $display("TB: sleep test done");
    endtask
    task automatic t_retune();
        wr(ADDR_USB_LOCK, 8'h00);
        wr(ADDR_FAST_TRIM, 8'h30);
        pulse(1'b1);
        chk(fast_trim, 8'h38);
        pulse(1'b0);
        rdc(ADDR_FAST_TRIM, 8'h30);
        wr(ADDR_USB_LOCK, 8'h01);
        pulse(1'b1);
        rdc(ADDR_FAST_TRIM, 8'h30);
        rdc(ADDR_USB_LOCK, 8'h01);
        // a write while the clock enable is low must not land
        clk_en <= 1'b0;
        wr(ADDR_FAST_TRIM, 8'h77);
        clk_en <= 1'b1;
        rdc(ADDR_FAST_TRIM, 8'h30);
        $display("TB: retune test done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("TB: checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // whole run is a few thousand cycles; the ceiling leaves wide margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_clocks();
        t_sleep();
        t_retune();
        conclude();
    end
endmodule
`default_nettype wire
